// file: verilog/psrs_pkg.sv
// Summary of operation
// - coefficient equals mantissa times two to exponent
// - 3-bit exponent setting, resets to binary 010
// - 19-bit signed 1.18 mantissa, resets to 25868h
// - supply reading is signed 2.22, 24 bits
// - live reading readable, updates continuously, resets zero
// - feedback path works only while enable set
package psrs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SMP_W = 24;
  localparam int MANT_W = 19;
  localparam int SHIFT_W = 3;
  localparam int PROD_W = SMP_W + MANT_W;
  localparam int WIDE_W = PROD_W + 7;
  localparam int FRAC_DROP = 18;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h34;
  localparam logic [7:0] ADDR_COEF_HI = 8'h35;
  localparam logic [7:0] ADDR_COEF_MID = 8'h36;
  localparam logic [7:0] ADDR_COEF_LO = 8'h37;
  localparam logic [7:0] ADDR_READ_HI = 8'h3B;
  localparam logic [7:0] ADDR_READ_MID = 8'h3C;
  localparam logic [7:0] ADDR_READ_LO = 8'h3D;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_FB_EN_BIT = 5;
  localparam int COEF_SHIFT_LSB = 4;
  localparam int COEF_MANT_HI_W = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 3'h2;
  localparam logic [MANT_W-1:0] MANT_RST = 19'h25868;
  localparam logic [SMP_W-1:0] READ_RST = 24'h000000;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // saturation limits of the 2.22 result
  // ----------------------------------------------------------------
  localparam logic [SMP_W-1:0] SAT_MAX = 24'h7FFFFF;
  localparam logic [SMP_W-1:0] SAT_MIN = 24'h800000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MANT_W-1:0] mant;
    logic [SHIFT_W-1:0] shift;
  } psrs_coef_s;

  typedef struct packed {
    logic valid;
    logic sat;
    logic [SMP_W-1:0] data;
  } psrs_corr_s;

endpackage : psrs_pkg

// file: verilog/psrs_mult.sv
`timescale 1ns/10ps
module psrs_mult
  import psrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [SMP_W-1:0] in_data,
  input wire psrs_coef_s coef,
  output psrs_corr_s out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic p_valid;
    logic signed [PROD_W-1:0] prod;
    logic [SHIFT_W-1:0] p_shift;
    psrs_corr_s res;
  } psrs_mult_state_s;

  psrs_mult_state_s st_r;
  psrs_mult_state_s st_nxt;
  logic signed [WIDE_W-1:0] wide;
  logic ovf;

  always_comb begin
    st_nxt = st_r;
    wide = WIDE_W'(st_r.prod) <<< st_r.p_shift;
    ovf = (wide[WIDE_W-1:PROD_W-2] != {(WIDE_W-PROD_W+2){wide[PROD_W-2]}});
    if (ce) begin
      st_nxt.p_valid = in_valid;
      st_nxt.p_shift = coef.shift;
      if (in_valid) begin
        st_nxt.prod = PROD_W'($signed(in_data) * $signed(coef.mant));
      end
      st_nxt.res.valid = st_r.p_valid;
      if (st_r.p_valid) begin
        st_nxt.res.sat = ovf;
        if (ovf) begin
          st_nxt.res.data = wide[WIDE_W-1] ? SAT_MIN : SAT_MAX;
        end else begin
          st_nxt.res.data = wide[FRAC_DROP+SMP_W-1:FRAC_DROP];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out = st_r.res;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_coef_unity;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && in_valid && coef.mant == 19'h20000 && coef.shift == 3'h1) ##1 ce
      |=> (out.data == $past(in_data, 2)) && !out.sat;
  endproperty
  a_coef_unity: assert property (p_coef_unity) else $error("unity coefficient changed the sample");

  property p_sat_limit;
    @(posedge sys_clk) disable iff (!arst_n)
    out.sat |-> (out.data == SAT_MAX || out.data == SAT_MIN);
  endproperty
  a_sat_limit: assert property (p_sat_limit) else $error("saturated result not at a limit");

  property p_zero_coef;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && in_valid && coef.mant == 19'h00000) ##1 ce |=> out.valid && out.data == 24'h000000;
  endproperty
  a_zero_coef: assert property (p_zero_coef) else $error("zero coefficient gave nonzero result");

endmodule : psrs_mult

// file: verilog/psrs_scaler.sv
`timescale 1ns/10ps
module psrs_scaler
  import psrs_pkg::*;
#(
  parameter int SAMPLE_W = SMP_W,
  parameter int MANTISSA_W = MANT_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic smp_valid,
  input wire logic [SMP_W-1:0] smp_data,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic feedback_en,
  output logic corr_valid,
  output logic corr_sat,
  output logic [SMP_W-1:0] corr_data
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SAMPLE_W != SMP_W) begin : g_bad_smp
    $error("sample width must be 24");
  end
  if (MANTISSA_W != MANT_W) begin : g_bad_mant
    $error("mantissa width must be 19");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fb_en;
    psrs_coef_s coef;
    logic [SHIFT_W-1:0] shd_shift;
    logic [COEF_MANT_HI_W-1:0] shd_mant_hi;
    logic [7:0] shd_mant_mid;
    logic [SMP_W-1:0] reading;
    logic [15:0] snap;
    logic [7:0] rdata;
    psrs_corr_s corr;
  } psrs_state_s;

  psrs_state_s st_r;
  psrs_state_s st_nxt;
  psrs_corr_s mult_out;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] byte_sel(input logic [23:0] word, input logic [1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      2'h2: b = word[23:16];
      2'h1: b = word[15:8];
      default: b = word[7:0];
    endcase
    return b;
  endfunction : byte_sel

  function automatic logic [7:0] coef_hi_byte(input logic [SHIFT_W-1:0] sh,
                                              input logic [COEF_MANT_HI_W-1:0] mh);
    logic [7:0] b;
    b = 8'h00;
    b[COEF_SHIFT_LSB +: SHIFT_W] = sh;
    b[COEF_MANT_HI_W-1:0] = mh;
    return b;
  endfunction : coef_hi_byte

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // live reading follows the decimator
      if (smp_valid) begin
        st_nxt.reading = smp_data;
      end

      // register writes
      if (reg_wr) begin
        if (reg_addr == ADDR_CTRL) begin
          st_nxt.fb_en = reg_wdata[CTRL_FB_EN_BIT];
        end else if (reg_addr == ADDR_COEF_HI) begin
          st_nxt.shd_shift = reg_wdata[COEF_SHIFT_LSB +: SHIFT_W];
          st_nxt.shd_mant_hi = reg_wdata[COEF_MANT_HI_W-1:0];
        end else if (reg_addr == ADDR_COEF_MID) begin
          st_nxt.shd_mant_mid = reg_wdata;
        end else if (reg_addr == ADDR_COEF_LO) begin
          // low byte commits the whole coefficient at once
          st_nxt.coef.shift = st_r.shd_shift;
          st_nxt.coef.mant = {st_r.shd_mant_hi, st_r.shd_mant_mid, reg_wdata};
        end
      end

      // register reads
      if (reg_rd) begin
        if (reg_addr == ADDR_CTRL) begin
          st_nxt.rdata = 8'h00;
          st_nxt.rdata[CTRL_FB_EN_BIT] = st_r.fb_en;
        end else if (reg_addr == ADDR_COEF_HI) begin
          st_nxt.rdata = coef_hi_byte(st_r.coef.shift, st_r.coef.mant[MANT_W-1:16]);
        end else if (reg_addr == ADDR_COEF_MID) begin
          st_nxt.rdata = st_r.coef.mant[15:8];
        end else if (reg_addr == ADDR_COEF_LO) begin
          st_nxt.rdata = st_r.coef.mant[7:0];
        end else if (reg_addr == ADDR_READ_HI) begin
          // high byte freezes the lower two for a coherent word
          st_nxt.rdata = byte_sel(st_r.reading, 2'h2);
          st_nxt.snap = st_r.reading[15:0];
        end else if (reg_addr == ADDR_READ_MID) begin
          st_nxt.rdata = byte_sel({8'h00, st_r.snap}, 2'h1);
        end else if (reg_addr == ADDR_READ_LO) begin
          st_nxt.rdata = byte_sel({8'h00, st_r.snap}, 2'h0);
        end else begin
          st_nxt.rdata = 8'h00;
        end
      end

      // correction output, cleared while feedback is off
      if (st_r.fb_en) begin
        st_nxt.corr = mult_out;
      end else begin
        st_nxt.corr = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.fb_en <= 1'b0;
      st_r.coef.shift <= SHIFT_RST;
      st_r.coef.mant <= MANT_RST;
      st_r.shd_shift <= SHIFT_RST;
      st_r.shd_mant_hi <= MANT_RST[MANT_W-1:16];
      st_r.shd_mant_mid <= MANT_RST[15:8];
      st_r.reading <= READ_RST;
      st_r.snap <= READ_RST[15:0];
      st_r.rdata <= RDATA_RST;
      st_r.corr <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // scaling pipeline
  // ----------------------------------------------------------------
  psrs_mult u_mult (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(smp_valid && st_r.fb_en),
    .in_data(smp_data),
    .coef(st_r.coef),
    .out(mult_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign feedback_en = st_r.fb_en;
  assign corr_valid = st_r.corr.valid;
  assign corr_sat = st_r.corr.sat;
  assign corr_data = st_r.corr.data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_shift_commit;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && reg_wr && reg_addr == ADDR_COEF_LO) |=> st_r.coef.shift == $past(st_r.shd_shift);
  endproperty
  a_shift_commit: assert property (p_shift_commit) else $error("exponent not committed");

  property p_mant_commit;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && reg_wr && reg_addr == ADDR_COEF_LO)
      |=> st_r.coef.mant == {$past(st_r.shd_mant_hi), $past(st_r.shd_mant_mid), $past(reg_wdata)};
  endproperty
  a_mant_commit: assert property (p_mant_commit) else $error("mantissa not committed");

  property p_coef_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !(ce && reg_wr && reg_addr == ADDR_COEF_LO) |=> $stable(st_r.coef);
  endproperty
  a_coef_hold: assert property (p_coef_hold) else $error("coefficient changed without commit");

  property p_read_update;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && smp_valid) |=> st_r.reading == $past(smp_data);
  endproperty
  a_read_update: assert property (p_read_update) else $error("reading did not follow sample");

  property p_read_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !(ce && smp_valid) |=> $stable(st_r.reading);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("reading moved without sample");

  property p_snap;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && reg_rd && reg_addr == ADDR_READ_HI)
      |=> st_r.snap == $past(st_r.reading[15:0]) && reg_rdata == $past(st_r.reading[23:16]);
  endproperty
  a_snap: assert property (p_snap) else $error("reading word not coherent");

  property p_fb_off;
    @(posedge sys_clk) disable iff (!arst_n)
    (!feedback_en && ce) |=> !corr_valid;
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("correction issued while feedback off");

  property p_corr_latency;
    @(posedge sys_clk) disable iff (!arst_n)
    (ce && smp_valid && feedback_en) ##1 (ce && feedback_en) ##1 (ce && feedback_en) |=> corr_valid;
  endproperty
  a_corr_latency: assert property (p_corr_latency) else $error("correction missing after sample");

endmodule : psrs_scaler

// file: verif/psrs_sample_src.sv
`timescale 1ns/10ps
module psrs_sample_src
  import psrs_pkg::*;
(
  input wire logic sys_clk,
  output logic smp_valid,
  output logic [SMP_W-1:0] smp_data
);
  initial begin
    smp_valid = 1'b0;
    smp_data = 24'h000000;
  end

  // one decimated 2.22 sample, strobed for a single cycle
  task automatic send(input logic [SMP_W-1:0] value);
    @(negedge sys_clk);
    smp_valid = 1'b1;
    smp_data = value;
    @(negedge sys_clk);
    smp_valid = 1'b0;
    // stale data must not look like a held sample
    smp_data = ~value;
  endtask : send
endmodule : psrs_sample_src

// file: verif/psrs_scaler_tb.sv
`timescale 1ns/10ps
module psrs_scaler_tb
  import psrs_pkg::*;
;
  logic sys_clk, arst_n, ce, smp_valid, reg_wr, reg_rd, feedback_en, corr_valid, corr_sat;
  logic [SMP_W-1:0] smp_data, corr_data;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int errors, check_count;
  logic [SMP_W-1:0] smp_tab [7] = '{24'h400000, 24'h400000, 24'h400000, 24'h400000, 24'hC00001, 24'h7FFFFF,
    24'h5A3C96};
  logic [MANT_W-1:0] mant_tab [7] = '{19'h20000, 19'h28851, 19'h40000, 19'h40000, 19'h20000, 19'h3FFFF,
    19'h00000};
  logic [SHIFT_W-1:0] exp_tab [7] = '{3'h1, 3'h2, 3'h0, 3'h3, 3'h0, 3'h0, 3'h7};

  psrs_scaler u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .smp_valid(smp_valid), .smp_data(smp_data),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .feedback_en(feedback_en), .corr_valid(corr_valid), .corr_sat(corr_sat), .corr_data(corr_data));

  psrs_sample_src u_src (.sys_clk(sys_clk), .smp_valid(smp_valid), .smp_data(smp_data));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // bench tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [SMP_W-1:0] got, input logic [SMP_W-1:0] want);
    check_count++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk({16'h0000, reg_rdata}, {16'h0000, want});
  endtask : rdchk

  task automatic set_coef(input logic [MANT_W-1:0] m, input logic [SHIFT_W-1:0] e);
    wr(ADDR_COEF_HI, {1'b0, e, 1'b0, m[18:16]});
    wr(ADDR_COEF_MID, m[15:8]);
    wr(ADDR_COEF_LO, m[7:0]);
  endtask : set_coef

  task automatic run_case(input logic [SMP_W-1:0] s, input logic [MANT_W-1:0] m, input logic [SHIFT_W-1:0] e);
    longint p;
    logic [SMP_W-1:0] want;
    logic sat;
    int n;
    set_coef(m, e);
    rdchk(ADDR_COEF_HI, {1'b0, e, 1'b0, m[18:16]});
    p = (longint'($signed(s)) * longint'($signed(m))) <<< e;
    p = p >>> 18;
    sat = (p > 64'sh7FFFFF) || (p < -64'sh800000);
    want = sat ? ((p > 0) ? SAT_MAX : SAT_MIN) : p[SMP_W-1:0];
    u_src.send(s);
    n = 0;
    while (corr_valid !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk(24'(n), 24'h2);
    chk(corr_data, want);
    chk({23'h0, corr_sat}, {23'h0, sat});
    @(negedge sys_clk);
    chk({23'h0, corr_valid}, 24'h0);
  endtask : run_case

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    check_count = 0;
    ce = 1'b1;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    rdchk(ADDR_READ_HI, 8'h00);
    rdchk(ADDR_READ_MID, 8'h00);
    rdchk(ADDR_READ_LO, 8'h00);
    rdchk(ADDR_COEF_HI, 8'h22);
    rdchk(ADDR_COEF_MID, 8'h58);
    rdchk(ADDR_COEF_LO, 8'h68);
    rdchk(ADDR_CTRL, 8'h00);
    rdchk(8'h3A, 8'h00);
    // feedback off: reading is live, correction stays quiet
    u_src.send(24'h400000);
    rdchk(ADDR_READ_HI, 8'h40);
    u_src.send(24'h5A3C96);
    repeat (3) @(negedge sys_clk);
    chk({23'h0, corr_valid}, 24'h0);
    chk(corr_data, 24'h000000);
    rdchk(ADDR_READ_HI, 8'h5A);
    rdchk(ADDR_READ_MID, 8'h3C);
    rdchk(ADDR_READ_LO, 8'h96);
    wr(ADDR_CTRL, 8'h20);
    chk({23'h0, feedback_en}, 24'h1);
    for (int i = 0; i < 7; i++) begin
      run_case(smp_tab[i], mant_tab[i], exp_tab[i]);
    end
    // clock enable low freezes a sample in flight
    set_coef(19'h20000, 3'h1);
    u_src.send(24'h123456);
    ce = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({23'h0, corr_valid}, 24'h0);
    ce = 1'b1;
    @(negedge sys_clk);
    chk({23'h0, corr_valid}, 24'h0);
    @(negedge sys_clk);
    chk({23'h0, corr_valid}, 24'h1);
    chk(corr_data, 24'h123456);
    wr(ADDR_CTRL, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk({23'h0, feedback_en}, 24'h0);
    chk(corr_data, 24'h000000);
    // reset in mid-run restores the coefficient and clears the reading
    arst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    rdchk(ADDR_COEF_HI, 8'h22);
    rdchk(ADDR_COEF_LO, 8'h68);
    rdchk(ADDR_READ_HI, 8'h00);
    rdchk(ADDR_READ_LO, 8'h00);
    complete_run();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
endmodule : psrs_scaler_tb
